/* File: core/dss_pkg.sv */
/*
 Constants for the disk sector sequencer: register offsets, instruction layout,
 branch codes and interrupt bits. Assumes a 32-bit classic Wishbone host.
*/
package dss_pkg;
	localparam int DSS_AW = 6;
	// Register byte offsets
	localparam logic [5:0] DSS_CTRL = 6'h00;
	localparam logic [5:0] DSS_STATUS = 6'h04;
	localparam logic [5:0] DSS_BRANCH = 6'h08;
	localparam logic [5:0] DSS_MARK = 6'h0c;
	localparam logic [5:0] DSS_CFG = 6'h10;
	localparam logic [5:0] DSS_STACK = 6'h14;
	localparam logic [5:0] DSS_PADDR = 6'h18;
	localparam logic [5:0] DSS_PDATA = 6'h1c;
	localparam logic [5:0] DSS_ISTAT = 6'h20;
	localparam logic [5:0] DSS_ICLR = 6'h24;
	localparam logic [5:0] DSS_IEN = 6'h28;
	// Instruction word: next[31:24] control[23:16] count_type[15:8] data[7:0]
	localparam int DSS_NEXT_LSB = 24;
	localparam int DSS_CTL_LSB = 16;
	localparam int DSS_TYP_LSB = 8;
	// Control field bits
	localparam int DSS_C_XFER = 0;
	localparam int DSS_C_CMP = 1;
	localparam int DSS_C_RGOFF = 3;
	localparam int DSS_C_STACK = 4;
	localparam int DSS_C_RGON = 6;
	// Count/type field bits (types valid only without transfer)
	localparam int DSS_T_CLK = 5;
	localparam int DSS_T_ECC = 6;
	localparam int DSS_T_AM = 7;
	localparam int DSS_T_CNTW = 5;
	// Branch condition in next[7:5]
	localparam logic [2:0] DSS_BR_NONE = 3'h0;
	localparam logic [2:0] DSS_BR_STOP = 3'h1;
	localparam logic [2:0] DSS_BR_INDEX = 3'h3;
	localparam logic [2:0] DSS_BR_SECT = 3'h4;
	localparam logic [2:0] DSS_BR_BAD = 3'h7;
	// Control register bits
	localparam int DSS_CTRL_GO = 0;
	localparam int DSS_CTRL_ABORT = 1;
	localparam int DSS_CTRL_PC_LSB = 8;
	// Interrupt bits
	localparam int DSS_NIRQ = 4;
	localparam int DSS_I_DONE = 0;
	localparam int DSS_I_INDEX = 1;
	localparam int DSS_I_SYNC = 2;
	localparam int DSS_I_FAIL = 3;
	localparam logic [7:0] DSS_BYTE_LAST = 8'h07;
	localparam logic [2:0] DSS_BIT_HALF = 3'h4;
	typedef enum logic [1:0] {DSS_IDLE, DSS_FETCH, DSS_EXEC} dss_state_t;
endpackage

/* File: core/dss_top.sv */
/*
 Disk sector sequencer: microprogrammed read side of a disk controller.
 Assumes the read clock, serial data, mark detect and index come from the
 drive's data separator asynchronously and are much slower than clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Push ID bytes to stack when saving enabled
// - Compare ID bytes to instruction data field
// - Sector branch only on full match, no ECC error
// - Hunt address mark after read gate on
// - Compare only selected mark pattern bits
// - Mark detection realigns byte framing
// - Start buffer clock at sync if asked
// - Count field is bytes minus one
// - ECC instruction checks and may stack bytes
// - Wait at own address for index, branch
// - Stack push discards bottom byte
module dss_top import dss_pkg::*; #(
	parameter int RAM_DEPTH = 32,
	parameter int STACK_DEPTH = 8
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [DSS_AW-1:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic rd_clk_i, // Read clock from separator
	input wire logic nrz_i, // Serial read data
	input wire logic mark_detect_pin_i, // Mark detect from separator
	input wire logic index_i, // Index pulse from drive
	output logic read_gate_o, // Read gate to drive
	output logic buffer_transfer_clock_o, // Buffer transfer clock
	output logic [7:0] buf_data_o, // Byte to buffer memory
	output logic buf_we_o, // Buffer write pulse
	output logic irq_o // Level interrupt
);
	localparam int PW = $clog2(RAM_DEPTH);
	localparam int SW = $clog2(STACK_DEPTH);
	if (RAM_DEPTH < 2 || RAM_DEPTH > 32 || (1 << PW) != RAM_DEPTH) begin : g_chk_ram
		$error("RAM_DEPTH must be a power of two from 2 to 32");
	end
	if (STACK_DEPTH < 2) begin : g_chk_stk
		$error("STACK_DEPTH must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection
	logic [3:0] in_s1_reg, in_s2_reg, in_s3_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_s1_reg <= 4'h0;
			in_s2_reg <= 4'h0;
			in_s3_reg <= 4'h0;
		end else begin
			in_s1_reg <= {index_i, mark_detect_pin_i, nrz_i, rd_clk_i};
			in_s2_reg <= in_s1_reg;
			in_s3_reg <= in_s2_reg;
		end
	end
	// Data is sampled at the synchronised read clock edge, same depth as the clock
	wire bit_tick = in_s2_reg[0] & ~in_s3_reg[0];
	wire nrz_bit = in_s2_reg[1];
	wire mark_seen = in_s2_reg[2];
	wire index_tick = in_s2_reg[3] & ~in_s3_reg[3];

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] ram [RAM_DEPTH];
	logic [7:0] branch_address_register, mark_pattern_register;
	logic [2:0] mark_compare_width;
	logic [PW-1:0] paddr_reg;
	logic [DSS_NIRQ-1:0] ien_reg, istat_reg, ev_next;
	logic [7:0] stack [STACK_DEPTH];
	logic ack_reg;
	logic [31:0] rdat_reg;
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	wire wb_rd = wb_req & ~wb_we_i;
	wire go = wb_wr && wb_adr_i == DSS_CTRL && wb_dat_i[DSS_CTRL_GO];
	wire abort = wb_wr && wb_adr_i == DSS_CTRL && wb_dat_i[DSS_CTRL_ABORT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			branch_address_register <= 8'h00;
			mark_pattern_register <= 8'h00;
			mark_compare_width <= 3'h7;
			paddr_reg <= '0;
			ien_reg <= '0;
		end else if (wb_wr) begin
			case (wb_adr_i)
				DSS_BRANCH: branch_address_register <= wb_dat_i[7:0];
				DSS_MARK: mark_pattern_register <= wb_dat_i[7:0];
				DSS_CFG: mark_compare_width <= wb_dat_i[2:0];
				DSS_PADDR: paddr_reg <= wb_dat_i[PW-1:0];
				DSS_PDATA: paddr_reg <= paddr_reg + 1'b1;
				DSS_IEN: ien_reg <= wb_dat_i[DSS_NIRQ-1:0];
				default: ;
			endcase
		end
	end

	// Program RAM; full words need all lanes
	always_ff @(posedge clk_i) begin
		if (wb_req && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == DSS_PDATA) begin
			ram[paddr_reg] <= wb_dat_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	dss_state_t state_reg;
	logic [PW-1:0] pc_reg;
	logic [31:0] ins_reg;
	logic [7:0] cnt_reg, shift_reg, ecc_reg;
	logic [2:0] bit_reg;
	logic synced_reg, cmp_fail_reg, ecc_err_reg, clk_run_reg, rg_reg;
	wire [7:0] ctl = ins_reg[DSS_CTL_LSB+:8];
	wire [7:0] typ = ins_reg[DSS_TYP_LSB+:8];
	wire [7:0] nxt = ins_reg[DSS_NEXT_LSB+:8];
	wire [2:0] br = nxt[7:5];
	wire xfer = ctl[DSS_C_XFER];
	wire is_am = ~xfer & typ[DSS_T_AM];
	wire is_ecc = ~xfer & typ[DSS_T_ECC];
	wire is_clk = ~xfer & typ[DSS_T_CLK];
	wire exec = state_reg == DSS_EXEC;
	wire [7:0] shifted = {shift_reg[6:0], nrz_bit};
	wire [7:0] mmask = 8'hff << (3'h7 - mark_compare_width);
	wire hunting = exec && is_am && !synced_reg && rg_reg && br != DSS_BR_INDEX;
	wire am_hit = hunting && bit_tick && mark_seen
		&& ((shifted ^ mark_pattern_register) & mmask) == 8'h00;
	wire byte_done = am_hit || (exec && synced_reg && bit_tick && bit_reg == DSS_BYTE_LAST[2:0]);
	wire [7:0] byte_val = shifted;
	wire ecc_bad = (ecc_reg ^ byte_val) != 8'h00;
	// An instruction with nothing to frame ends at once
	wire quick = exec && br != DSS_BR_INDEX && !is_am && !synced_reg;
	wire last = (byte_done && cnt_reg == 8'h00) || quick;
	wire idx_done = exec && br == DSS_BR_INDEX && index_tick;
	wire cmp_bad = byte_done && ctl[DSS_C_CMP] && byte_val != ins_reg[7:0];
	wire ecc_now = byte_done && is_ecc && last && ecc_bad;
	wire fail_all = cmp_fail_reg | cmp_bad | ecc_err_reg | ecc_now;
	logic [PW-1:0] pc_next;

	always_comb begin
		pc_next = nxt[PW-1:0];
		case (br)
			DSS_BR_INDEX: pc_next = branch_address_register[PW-1:0];
			DSS_BR_SECT: pc_next = fail_all ? pc_reg + 1'b1
				: branch_address_register[PW-1:0];
			DSS_BR_BAD: pc_next = (cmp_fail_reg | cmp_bad) ? branch_address_register[PW-1:0]
				: nxt[PW-1:0];
			default: pc_next = nxt[PW-1:0];
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || abort) begin
			state_reg <= DSS_IDLE;
			pc_reg <= '0;
			ins_reg <= 32'h0;
			cnt_reg <= 8'h00;
		end else begin
			case (state_reg)
				DSS_IDLE: if (go) begin
					pc_reg <= wb_dat_i[DSS_CTRL_PC_LSB+:PW];
					state_reg <= DSS_FETCH;
				end
				DSS_FETCH: begin
					ins_reg <= ram[pc_reg];
					cnt_reg <= ram[pc_reg][DSS_CTL_LSB+DSS_C_XFER] ? ram[pc_reg][DSS_TYP_LSB+:8]
						: {3'h0, ram[pc_reg][DSS_TYP_LSB+:DSS_T_CNTW]};
					state_reg <= DSS_EXEC;
				end
				DSS_EXEC: if (last || idx_done) begin
					pc_reg <= pc_next;
					state_reg <= (br == DSS_BR_STOP) ? DSS_IDLE : DSS_FETCH;
				end else if (byte_done) begin
					cnt_reg <= cnt_reg - 1'b1;
				end
				default: state_reg <= DSS_IDLE;
			endcase
		end
	end

	// Read gate and byte framing
	always_ff @(posedge clk_i) begin
		if (rst_i || abort) begin
			rg_reg <= 1'b0;
			synced_reg <= 1'b0;
			bit_reg <= 3'h0;
			shift_reg <= 8'h00;
			clk_run_reg <= 1'b0;
		end else begin
			if (state_reg == DSS_FETCH && ram[pc_reg][DSS_CTL_LSB+DSS_C_RGON]) begin
				rg_reg <= 1'b1;
			end else if (state_reg == DSS_FETCH && ram[pc_reg][DSS_CTL_LSB+DSS_C_RGOFF]) begin
				rg_reg <= 1'b0;
			end
			if (bit_tick) begin
				shift_reg <= shifted;
				bit_reg <= bit_reg + 1'b1;
			end
			if (am_hit) begin
				synced_reg <= 1'b1;
				bit_reg <= 3'h0;
				clk_run_reg <= clk_run_reg | is_clk;
			end
			if (!rg_reg || (exec && last && br == DSS_BR_STOP)) begin
				synced_reg <= 1'b0;
				clk_run_reg <= 1'b0;
			end
		end
	end

	// Compare and ECC results; cleared when a sequence starts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_fail_reg <= 1'b0;
			ecc_err_reg <= 1'b0;
			ecc_reg <= 8'h00;
		end else begin
			// A result in the cycle of a new start is kept: set wins over clear
			cmp_fail_reg <= (cmp_fail_reg & ~go) | cmp_bad;
			ecc_err_reg <= (ecc_err_reg & ~go) | ecc_now;
			// Field check: XOR of all bytes since the mark, ECC bytes included, must be zero
			if (go || am_hit) begin
				ecc_reg <= 8'h00;
			end else if (byte_done) begin
				ecc_reg <= is_ecc && last ? 8'h00 : ecc_reg ^ byte_val;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack: push wins over a same-cycle read recirculation
	wire push = byte_done && ctl[DSS_C_STACK];
	wire pop = wb_rd && wb_adr_i == DSS_STACK;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack[i] <= 8'h00;
			end
		end else if (push) begin
			stack[0] <= byte_val;
			for (int i = 1; i < STACK_DEPTH; i++) begin
				stack[i] <= stack[i-1];
			end
		end else if (pop) begin
			stack[STACK_DEPTH-1] <= stack[0];
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				stack[i] <= stack[i+1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer side
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_data_o <= 8'h00;
			buf_we_o <= 1'b0;
			buffer_transfer_clock_o <= 1'b0;
			read_gate_o <= 1'b0;
		end else begin
			buf_we_o <= byte_done && xfer;
			if (byte_done && xfer) begin
				buf_data_o <= byte_val;
			end
			// High over the back half of a byte in progress, so a byte that ends
			// a sequence cannot leave a stray short pulse behind it
			buffer_transfer_clock_o <= clk_run_reg && synced_reg && bit_reg >= DSS_BIT_HALF;
			read_gate_o <= rg_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over clear
	always_comb begin
		ev_next = '0;
		ev_next[DSS_I_DONE] = exec && (last || idx_done) && br == DSS_BR_STOP;
		ev_next[DSS_I_INDEX] = index_tick;
		ev_next[DSS_I_SYNC] = am_hit;
		ev_next[DSS_I_FAIL] = cmp_bad | ecc_now;
	end
	wire [DSS_NIRQ-1:0] clr = (wb_wr && wb_adr_i == DSS_ICLR) ? wb_dat_i[DSS_NIRQ-1:0] : '0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			istat_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			istat_reg <= (istat_reg & ~clr) | ev_next;
			irq_o <= |(((istat_reg & ~clr) | ev_next) & ien_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone read path, one-cycle answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
		end else begin
			ack_reg <= wb_req;
			rdat_reg <= 32'h0;
			if (wb_rd) begin
				case (wb_adr_i)
					DSS_STATUS: rdat_reg <= {16'h0, 3'h0, pc_reg[PW-1:0] | 5'h00,
						1'b0, clk_run_reg, rg_reg, synced_reg,
						ecc_err_reg, cmp_fail_reg, state_reg};
					DSS_BRANCH: rdat_reg <= {24'h0, branch_address_register};
					DSS_MARK: rdat_reg <= {24'h0, mark_pattern_register};
					DSS_CFG: rdat_reg <= {29'h0, mark_compare_width};
					DSS_STACK: rdat_reg <= {24'h0, stack[0]};
					DSS_PADDR: rdat_reg <= {{(32-PW){1'b0}}, paddr_reg};
					DSS_PDATA: rdat_reg <= ram[paddr_reg];
					DSS_ISTAT: rdat_reg <= {{(32-DSS_NIRQ){1'b0}}, istat_reg};
					DSS_IEN: rdat_reg <= {{(32-DSS_NIRQ){1'b0}}, ien_reg};
					default: rdat_reg <= 32'h0;
				endcase
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
endmodule
`default_nettype wire

/* File: testbench/dss_drive_model.sv */
/*
 Behavioural drive side: read clock, serial data, mark detect, index.
 Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_drive_model (
	input wire logic read_gate_i, // Read gate
	output logic rd_clk_o, // Read clock, still between bytes
	output logic nrz_o, // Serial data
	output logic mark_o, // Mark detect
	output logic index_o // Index pulse
);
	initial begin
		rd_clk_o = 1'b0;
		nrz_o = 1'b0;
		mark_o = 1'b0;
		index_o = 1'b0;
	end
	////////////////////////////////////////
	// MSB first, 125 ns cells; data moves on the falling edge
	task automatic send(input logic [7:0] b, input logic m);
		for (int i = 7; i >= 0; i--) begin
			nrz_o = b[i];
			mark_o = m && (i == 0) && read_gate_i;
			#62.5 rd_clk_o = 1'b1;
			#62.5 rd_clk_o = 1'b0;
		end
		// A released line must not keep the last bit
		nrz_o = ~b[0];
		mark_o = 1'b0;
	endtask
	task automatic pulse_index;
		#200 index_o = 1'b1;
		#500 index_o = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: testbench/dss_top_asserts.sv */
/*
 Port checks of dss_top, bound into it.
 Assumes a classic Wishbone master and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_top_asserts import dss_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [DSS_AW-1:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire logic rd_clk_i, // Read clock
	input wire logic nrz_i, // Serial data
	input wire logic mark_detect_pin_i, // Mark detect
	input wire logic index_i, // Index
	input wire logic read_gate_o, // Read gate
	input wire logic buffer_transfer_clock_o, // Buffer clock
	input wire logic [7:0] buf_data_o, // Buffer byte
	input wire logic buf_we_o, // Buffer write
	input wire logic irq_o // Interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_rdat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside answer");
	a_we_gap: assert property (
		buf_we_o |=> !buf_we_o [*8])
		else $error("buffer writes too close");
	a_bclk_width: assert property (
		$rose(buffer_transfer_clock_o) |=> buffer_transfer_clock_o [*8])
		else $error("buffer clock pulse short");
	a_bclk_gate: assert property (
		buffer_transfer_clock_o |-> read_gate_o || $past(read_gate_o) || $past(read_gate_o, 2))
		else $error("buffer clock without read gate");
	a_irq_mask: assert property ((wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
		wb_adr_i == DSS_IEN && wb_sel_i[0] && wb_dat_i[3:0] == 4'h0) |-> ##[1:3] !irq_o)
		else $error("masked interrupt stays");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !read_gate_o && !irq_o && !buf_we_o && !wb_ack_o)
		else $error("output active after reset");
endmodule
bind dss_top dss_top_asserts dss_top_asserts_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rd_clk_i, .nrz_i,
	.mark_detect_pin_i, .index_i, .read_gate_o, .buffer_transfer_clock_o, .buf_data_o,
	.buf_we_o, .irq_o);
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 Bench for dss_top: register table, three ID runs, stack, reset.
 Assumes dss_drive_model on the drive side and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench import dss_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [DSS_AW-1:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rdat;
	logic wb_ack_o, rd_clk_i, nrz_i, mark_detect_pin_i, index_i, read_gate_o;
	logic buffer_transfer_clock_o, buf_we_o, irq_o, xfer = 1'b0;
	logic [7:0] buf_data_o;
	logic [63:0] run;
	int num_errors = 0, samples_checked = 0, cycles = 0, nwe = 0, nbclk = 0;
	// {address, write, data, expected}
	localparam logic [22:0] ROWS [8] = '{{DSS_BRANCH, 1'b0, 8'h00, 8'h00},
		{DSS_MARK, 1'b0, 8'h00, 8'h00}, {DSS_CFG, 1'b0, 8'h00, 8'h07},
		{DSS_PADDR, 1'b0, 8'h00, 8'h00}, {DSS_IEN, 1'b0, 8'h00, 8'h00},
		{DSS_ISTAT, 1'b0, 8'h00, 8'h00}, {6'h3c, 1'b1, 8'ha5, 8'h00}, {6'h3c, 1'b0, 8'h00, 8'h00}};
	localparam logic [31:0] PROG [8] = '{32'h60000000, 32'h02400000, 32'h0300a000,
		32'h0412005a, 32'h0512003c, 32'h86104100, 32'h26080000, 32'h3001ff00};
	// {mark, width, id and ecc bytes, interrupt status, status flags}
	localparam logic [63:0] RUNS [3] = '{64'ha1075a3c66000700, 64'ha1075b3c67000f04,
		64'haf035a3c66010f08};
	localparam logic [7:0] STK [9] = '{8'h01, 8'h66, 8'h3c, 8'h5a, 8'h00, 8'h67, 8'h3c,
		8'h5b, 8'h01};
	dss_top dss_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .rd_clk_i, .nrz_i, .mark_detect_pin_i, .index_i,
		.read_gate_o, .buffer_transfer_clock_o, .buf_data_o, .buf_we_o, .irq_o);
	dss_drive_model dss_drive_model_i (.read_gate_i(read_gate_o), .rd_clk_o(rd_clk_i),
		.nrz_o(nrz_i), .mark_o(mark_detect_pin_i), .index_o(index_i));
	always #5 clk_i = ~clk_i;
	always @(posedge buffer_transfer_clock_o) nbclk++;
	always @(posedge clk_i) begin
		if (xfer && buf_we_o === 1'b1) begin
			check(32'(buf_data_o), 32'(nwe[7:0]));
			nwe++;
		end
	end
	// Cuts a hang short
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		check(rdat, e);
	endtask
	// The interrupt output lags an enable write by two registers
	task automatic settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ROWS[i]) begin
			if (ROWS[i][16])
				bus(ROWS[i][22:17], 1'b1, 32'(ROWS[i][15:8]));
			else
				rd(ROWS[i][22:17], 32'(ROWS[i][7:0]));
		end
		foreach (PROG[i]) begin
			bus(DSS_PADDR, 1'b1, (i == 7) ? 32'h10 : 32'(i));
			bus(DSS_PDATA, 1'b1, PROG[i]);
		end
		foreach (RUNS[r]) begin
			run = RUNS[r];
			bus(DSS_BRANCH, 1'b1, 32'h01);
			bus(DSS_MARK, 1'b1, 32'ha1);
			bus(DSS_CFG, 1'b1, 32'(run[55:48]));
			bus(DSS_IEN, 1'b1, 32'h1);
			bus(DSS_CTRL, 1'b1, 32'h1);
			settle();
			check(32'(read_gate_o), 32'(r == 1));
			dss_drive_model_i.pulse_index();
			wait (read_gate_o === 1'b1);
			bus(DSS_BRANCH, 1'b1, 32'h10);
			dss_drive_model_i.send(8'ha1, 1'b0);
			dss_drive_model_i.send(run[63:56], 1'b1);
			for (int k = 47; k >= 16; k -= 8)
				dss_drive_model_i.send(run[k-:8], 1'b0);
			xfer = (r == 0);
			for (int k = 0; k < 256 && xfer; k++)
				dss_drive_model_i.send(8'(k), 1'b0);
			wait (irq_o === 1'b1);
			xfer = 1'b0;
			rd(DSS_ISTAT, 32'(run[15:8]));
			bus(DSS_STATUS, 1'b0, 32'h0);
			check(32'(rdat[3:0]), 32'(run[3:0]));
			check(32'(read_gate_o), 32'(r == 0));
			bus(DSS_IEN, 1'b1, 32'h0);
			settle();
			check(32'(irq_o), 32'h0);
			bus(DSS_ICLR, 1'b1, 32'hf);
			bus(DSS_IEN, 1'b1, 32'hf);
			settle();
			check(32'(irq_o), 32'h0);
			rd(DSS_ISTAT, 32'h0);
		end
		check(32'(nwe), 32'h100);
		check(32'(nbclk >= 256), 32'h1);
		foreach (STK[i])
			rd(DSS_STACK, 32'(STK[i]));
		bus(DSS_CTRL, 1'b1, 32'h1);
		bus(DSS_CTRL, 1'b1, 32'h2);
		rd(DSS_STATUS, 32'h0);
		bus(DSS_CTRL, 1'b1, 32'h1);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(DSS_BRANCH, 32'h0);
		rd(DSS_STACK, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
